// ==== spi_peer.sv ====
// behavioural slave device on the far side of the serial link
`timescale 1ns/1ps
module spi_peer (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       clock_idle_level,
  input  wire logic       clock_sample_phase,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  output logic      [7:0] rx,
  output logic            miso
);
  int         n = 0;
  logic       mq = 1'b1;
  logic [2:0] k;
  logic       bitv;
  always @(negedge sel_n) n = 0;
  always @(sck) begin
    if (!sel_n) begin
      if ((sck != clock_idle_level) ^ clock_sample_phase) rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      else n = n + 1;
    end
  end
  // with late phase the first leading edge only presents bit zero
  assign k = 3'(clock_sample_phase ? (n > 0 ? n - 1 : 0) : n);
  assign bitv = tx[lsb ? k : 3'h7 - k];
  // a released line shows the inverse of its last level, not a held copy
  always @(posedge sel_n) mq = ~bitv;
  assign miso = sel_n ? mq : bitv;
endmodule

// ==== spi_pkg.sv ====
// constants, carrier types and divider decode for the serial port
package spi_pkg;
  localparam int          ADDR_W          = 2;
  localparam logic [1:0]  OFS_CONTROL     = 2'h0;
  localparam logic [1:0]  OFS_STATUS      = 2'h1;
  localparam logic [1:0]  OFS_DATA        = 2'h2;
  localparam int          BIT_IRQ_EN      = 7;
  localparam int          BIT_PORT_EN     = 6;
  localparam int          BIT_LSB_FIRST   = 5;
  localparam int          BIT_MASTER      = 4;
  localparam int          BIT_IDLE_LVL    = 3;
  localparam int          BIT_SAMPLE_PH   = 2;
  localparam int          BIT_RATE_HI     = 1;
  localparam int          BIT_RATE_LO     = 0;
  localparam int          BIT_DONE        = 7;
  localparam int          BIT_WRITE_COLLISION_FLAG        = 6;
  localparam int          BIT_DOUBLE      = 0;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [7:0]  DATA_RESET      = 8'h00;
  localparam logic [2:0]  LAST_BIT        = 3'h7;
  localparam logic [3:0]  LAST_EDGE       = 4'hF;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_MASTER = 2'b01,
    ST_SLAVE  = 2'b11
  } port_state_t;

  typedef struct packed {
    logic sck_in;
    logic mosi_in;
    logic miso_in;
    logic ss_n_in;
  } spi_pins_in_t;

  typedef struct packed {
    logic sck_out;
    logic sck_oe;
    logic mosi_out;
    logic mosi_oe;
    logic miso_out;
    logic miso_oe;
  } spi_pins_out_t;

  // half of the serial clock period in system clocks
  function automatic logic [5:0] half_period(input logic       dbl,
                                             input logic [1:0] rate);
    logic [7:0] div;
    div = 8'h04;
    case ({dbl, rate})
      3'b000:  div = 8'h04;
      3'b001:  div = 8'h10;
      3'b010:  div = 8'h40;
      3'b011:  div = 8'h80;
      3'b100:  div = 8'h02;
      3'b101:  div = 8'h08;
      3'b110:  div = 8'h20;
      default: div = 8'h40;
    endcase
    // a half of 64 wraps to 0; the counter then still spans 64 cycles
    return div[6:1];
  endfunction
endpackage

// ==== spi_port.sv ====
// byte-wide serial peripheral port, master or slave, with register port
`timescale 1ns/1ps
module spi_port (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic [spi_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [7:0]                rdata,
  input  wire logic                      global_irq_enable,
  input  wire logic                      irq_vector_ack,
  input  wire logic                      ss_is_input,
  input  wire spi_pkg::spi_pins_in_t     pins_in,
  output spi_pkg::spi_pins_out_t         pins_out,
  output logic                           irq
);
  import spi_pkg::*;

  logic [7:0]  control_r;
  logic        double_r;
  logic        done_r;
  logic        write_collision_flag_r;
  logic        armed_r;
  logic [7:0]  rdata_r;
  logic [7:0]  tx_r;
  logic [7:0]  rx_r;
  logic [7:0]  rbuf_r;
  logic [2:0]  bit_cnt_r;
  logic [3:0]  edge_cnt_r;
  logic [5:0]  half_cnt_r;
  logic        sck_phase_r;
  logic        first_r;
  port_state_t state_r;
  logic        sck_s1_r, sck_s2_r, sck_s3_r;
  logic        mosi_s1_r, mosi_s2_r;
  logic        ss_s1_r, ss_s2_r;

  logic        enabled, lsb_first, idle_lvl, sample_ph, is_master;
  logic        wr_ctrl, wr_stat, wr_data, rd_stat, data_acc;
  logic        busy, start, fault, slave_sel;
  logic        edge_ev, lead, sample_ev, setup_ev, din;
  logic        byte_rx, master_end;
  logic [7:0]  rx_nxt;
  logic [5:0]  half;

  assign enabled   = control_r[BIT_PORT_EN];
  assign lsb_first = control_r[BIT_LSB_FIRST];
  assign idle_lvl  = control_r[BIT_IDLE_LVL];
  assign sample_ph = control_r[BIT_SAMPLE_PH];
  assign is_master = control_r[BIT_MASTER];

  assign wr_ctrl  = wr && addr == OFS_CONTROL;
  assign wr_stat  = wr && addr == OFS_STATUS;
  assign wr_data  = wr && addr == OFS_DATA;
  assign rd_stat  = rd && addr == OFS_STATUS;
  assign data_acc = (wr || rd) && addr == OFS_DATA;

  assign busy  = state_r != ST_IDLE;
  // a master transfer is started only by a write while nothing is shifting
  assign start = wr_data && !busy && enabled && is_master;
  assign fault = enabled && is_master && ss_is_input && !ss_s2_r;
  assign slave_sel = enabled && !is_master && !ss_s2_r;
  assign half = half_period(double_r,
                            control_r[BIT_RATE_HI:BIT_RATE_LO]);

  // pin sampling; the slave clock is seen two cycles late, which is why an
  // external clock phase must last longer than two system clocks
  always_ff @(posedge clk) begin
    if (reset) begin
      sck_s1_r  <= 1'b0;
      sck_s2_r  <= 1'b0;
      sck_s3_r  <= 1'b0;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
      ss_s1_r   <= 1'b1;
      ss_s2_r   <= 1'b1;
    end else begin
      sck_s1_r  <= pins_in.sck_in;
      sck_s2_r  <= sck_s1_r;
      sck_s3_r  <= sck_s2_r;
      mosi_s1_r <= pins_in.mosi_in;
      mosi_s2_r <= mosi_s1_r;
      ss_s1_r   <= pins_in.ss_n_in;
      ss_s2_r   <= ss_s1_r;
    end
  end

  // one edge strobe shared by both roles
  always_comb begin
    edge_ev = 1'b0;
    lead    = 1'b0;
    din     = 1'b0;
    if (state_r == ST_MASTER) begin
      edge_ev = half_cnt_r == half - 6'h01;
      lead    = !edge_cnt_r[0];
      din     = pins_in.miso_in;
    end else if (state_r == ST_SLAVE ||
                 (state_r == ST_IDLE && slave_sel)) begin
      // idle must see the first slave edge too, or its sample is lost
      // slave timing follows the external clock only
      edge_ev = sck_s2_r != sck_s3_r;
      lead    = sck_s2_r != idle_lvl;
      din     = mosi_s2_r;
    end
  end

  assign sample_ev = edge_ev && (lead ^ sample_ph);
  assign setup_ev  = edge_ev && !(lead ^ sample_ph) && !(first_r && lead);
  assign rx_nxt    = lsb_first ? {din, rx_r[7:1]}
                               : {rx_r[6:0], din};
  assign byte_rx    = sample_ev && bit_cnt_r == LAST_BIT;
  assign master_end = state_r == ST_MASTER && edge_ev &&
                      edge_cnt_r == LAST_EDGE;

  // role and transfer state
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else if (!enabled || fault) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_MASTER;
          end else if (slave_sel && sck_s2_r != sck_s3_r) begin
            state_r <= ST_SLAVE;
          end
        end
        ST_MASTER: begin
          if (master_end || !is_master) begin
            state_r <= ST_IDLE;
          end
        end
        ST_SLAVE: begin
          // deselect drops partial bits
          if (!slave_sel || byte_rx) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // master clock generator
  always_ff @(posedge clk) begin
    if (reset || state_r != ST_MASTER) begin
      half_cnt_r  <= 6'h00;
      edge_cnt_r  <= 4'h0;
      sck_phase_r <= 1'b0;
    end else if (edge_ev) begin
      half_cnt_r  <= 6'h00;
      edge_cnt_r  <= edge_cnt_r + 4'h1;
      sck_phase_r <= !sck_phase_r;
    end else begin
      half_cnt_r  <= half_cnt_r + 6'h01;
    end
  end

  // bit counter and receive shifter
  always_ff @(posedge clk) begin
    if (reset || !enabled) begin
      bit_cnt_r <= 3'h0;
      rx_r      <= 8'h00;
      first_r   <= 1'b1;
    end else if (state_r == ST_IDLE && !(slave_sel && edge_ev_idle())) begin
      bit_cnt_r <= 3'h0;
      first_r   <= 1'b1;
    end else if (state_r == ST_SLAVE && !slave_sel) begin
      bit_cnt_r <= 3'h0;
      first_r   <= 1'b1;
    end else if (edge_ev) begin
      first_r <= 1'b0;
      if (sample_ev) begin
        rx_r      <= rx_nxt;
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
    end
  end

  // a slave byte begins on the edge that moves the port out of idle
  function automatic logic edge_ev_idle();
    return sck_s2_r != sck_s3_r;
  endfunction

  // transmit shifter; the only transmit buffer there is
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_r <= DATA_RESET;
    end else if (wr_data && !busy) begin
      tx_r <= wdata;
    end else if (setup_ev) begin
      tx_r <= lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
    end
  end

  // receive buffer holds the last byte while the next shifts in
  always_ff @(posedge clk) begin
    if (reset) begin
      rbuf_r <= DATA_RESET;
    end else if (byte_rx) begin
      rbuf_r <= rx_nxt;
    end
  end

  // control register; a mode fault drops the master bit
  always_ff @(posedge clk) begin
    if (reset) begin
      control_r <= CONTROL_RESET;
      double_r  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        control_r <= wdata;
      end
      if (fault) begin
        control_r[BIT_MASTER] <= 1'b0;
      end
      if (wr_stat) begin
        double_r <= wdata[BIT_DOUBLE];
      end
    end
  end

  // status flags; a new event in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (reset) begin
      done_r  <= 1'b0;
      write_collision_flag_r  <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      if (rd_stat) begin
        armed_r <= done_r || write_collision_flag_r;
      end else if (data_acc) begin
        armed_r <= 1'b0;
      end
      if (data_acc && armed_r) begin
        done_r <= 1'b0;
        write_collision_flag_r <= 1'b0;
      end
      if (irq_vector_ack) begin
        done_r <= 1'b0;
      end
      // colliding write is dropped; tx_r loads only when idle
      if (wr_data && busy) begin
        write_collision_flag_r <= 1'b1;
      end
      if (master_end || (state_r == ST_SLAVE && byte_rx) || fault) begin
        done_r <= 1'b1;
      end
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (rd) begin
      case (addr)
        OFS_CONTROL: rdata_r <= control_r;
        OFS_STATUS:  rdata_r <= {done_r, write_collision_flag_r, 5'h00, double_r};
        OFS_DATA:    rdata_r <= rbuf_r;
        default:     rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata = rdata_r;
  assign irq   = done_r && control_r[BIT_IRQ_EN] && global_irq_enable;

  always_comb begin
    pins_out.sck_out  = idle_lvl ^ sck_phase_r;
    pins_out.sck_oe   = enabled && is_master;
    pins_out.mosi_out = lsb_first ? tx_r[0] : tx_r[7];
    pins_out.mosi_oe  = enabled && is_master;
    pins_out.miso_out = lsb_first ? tx_r[0] : tx_r[7];
    pins_out.miso_oe  = slave_sel;
  end
endmodule

// ==== spi_port_props.sv ====
// bound checker for register and pin behaviour of the serial port
`timescale 1ns/1ps
module spi_port_props (
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic [spi_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0]                 wdata,
  input wire logic                       wr,
  input wire logic                       rd,
  input wire logic [7:0]                 rdata,
  input wire logic                       global_irq_enable,
  input wire logic                       irq_vector_ack,
  input wire logic                       ss_is_input,
  input wire spi_pkg::spi_pins_in_t      pins_in,
  input wire spi_pkg::spi_pins_out_t     pins_out,
  input wire logic                       irq
);
  import spi_pkg::*;
  // shadow of control; a mode fault clears role inside, so role checks
  // are gated by the select pin being an output
  logic [7:0] ctl_r;
  always_ff @(posedge clk) begin
    if (reset) ctl_r <= 8'h00;
    else if (wr && addr == OFS_CONTROL) ctl_r <= wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_irq_gate: assert property (irq |-> global_irq_enable && ctl_r[7])
    else $error("irq without both enables");
  a_ack_clears: assert property (irq_vector_ack && irq |=> !irq)
    else $error("vector ack left irq up");
  a_status_rsvd: assert property (rd && addr == OFS_STATUS |=>
    rdata[5:1] == 5'h00) else $error("reserved status bits set");
  a_port_off: assert property (!ctl_r[BIT_PORT_EN] |->
    !pins_out.sck_oe && !pins_out.mosi_oe && !pins_out.miso_oe)
    else $error("pins driven while disabled");
  a_master_drv: assert property (ctl_r[6] && ctl_r[4] && !ss_is_input
    |-> pins_out.sck_oe && !pins_out.miso_oe) else $error("master oe");
  a_idle_level: assert property (wr && addr == OFS_CONTROL && wdata[6]
    |-> ##2 pins_out.sck_out == ctl_r[BIT_IDLE_LVL]) else $error("idle sck");
  a_mode_fault: assert property ($fell(pins_in.ss_n_in) && ss_is_input
    && pins_out.sck_oe |-> ##[1:3] !pins_out.sck_oe) else $error("no fault");
  a_ss_release: assert property (pins_in.ss_n_in [*3]
    |-> !pins_out.miso_oe) else $error("miso driven while deselected");
endmodule
bind spi_port spi_port_props u_props (.clk, .reset, .addr, .wdata, .wr, .rd,
  .rdata, .global_irq_enable, .irq_vector_ack, .ss_is_input, .pins_in,
  .pins_out, .irq);

// ==== tb_spi_port.sv ====
// self-checking bench for the serial port
`timescale 1ns/1ps
`define CHK(s, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", s, e, g); end end
module tb_spi_port;
  import spi_pkg::*;
  localparam int DIV [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
  logic          clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0;
  logic          gie = 1'b0, ack = 1'b0, ssin = 1'b0, irq, pmiso;
  logic          ssck = 1'b0, smosi = 1'b0, ss_n = 1'b1, sel_n = 1'b1;
  logic          clock_idle_level = 1'b0, clock_sample_phase = 1'b0, lsb = 1'b0;
  logic [1:0]    addr = 2'h0;
  logic [7:0]    wdata = 8'h00, rdata, ptx = 8'h00, prx, d, got;
  spi_pins_in_t  pin;
  spi_pins_out_t po;
  int            n_fail = 0, n_tests = 0, cnt, edges, h, j;
  always #10 clk = ~clk;
  always @(po.sck_out) edges++;
  assign pin = '{sck_in: ssck, mosi_in: smosi, miso_in: pmiso, ss_n_in: ss_n};
  spi_port DUT (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata,
    .global_irq_enable(gie), .irq_vector_ack(ack), .ss_is_input(ssin),
    .pins_in(pin), .pins_out(po), .irq);
  spi_peer u_peer (.sck(po.sck_out), .mosi(po.mosi_out), .sel_n, .clock_idle_level,
    .clock_sample_phase, .lsb, .tx(ptx), .rx(prx), .miso(pmiso));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [1:0] a, input logic [7:0] e, input string s);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(s, e, rdata)
  endtask
  // external master: three cycles per phase keeps well under a quarter rate
  task automatic sbyte(input logic [7:0] b, input int n);
    for (int k = 0; k < n; k++) begin
      smosi <= b[7 - k];
      repeat (3) @(posedge clk);
      ssck <= 1'b1;
      @(posedge clk);
      // read one cycle after the rise, clear of any shift edge
      got = {got[6:0], po.miso_out};
      repeat (2) @(posedge clk);
      ssck <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rreg(OFS_CONTROL, 8'h00, "control");
    rreg(OFS_STATUS, 8'h00, "status");
    wreg(2'h3, 8'hFF);
    rreg(2'h3, 8'h00, "unmapped");
    rreg(OFS_CONTROL, 8'h00, "control");
    gie <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      {lsb, clock_sample_phase, clock_idle_level} = 3'(i);
      j = 7 - i;
      h = DIV[j] / 2;
      d = 8'hA5 ^ 8'(i * 37);
      ptx = ~d;
      wreg(OFS_CONTROL, {2'b11, lsb, 1'b1, clock_idle_level, clock_sample_phase, 2'(j)});
      wreg(OFS_STATUS, {7'h00, j[2]});
      sel_n = 1'b0;
      edges = 0;
      wreg(OFS_DATA, d);
      cnt = 0;
      while (irq !== 1'b1 && cnt < 2100) begin
        if (i == 1 && cnt == 5) wreg(OFS_DATA, 8'h3C);
        @(posedge clk);
        #1 cnt++;
      end
      if (cnt >= 2100) begin
        n_fail++;
        conclude();
      end
      if (i != 1) `CHK("rate", 1'b1, cnt >= 16 * h && cnt <= 16 * h + 2)
      `CHK("edges", 16, edges)
      `CHK("sck idle", clock_idle_level, po.sck_out)
      `CHK("peer rx", d, prx)
      sel_n = 1'b1;
      if (i[0]) begin
        rreg(OFS_STATUS, {1'b1, i == 1, 5'h00, j[2]}, "flags");
        rreg(OFS_DATA, ~d, "rx data");
      end else begin
        gie <= 1'b0;
        #1 `CHK("irq masked", 1'b0, irq)
        gie <= 1'b1;
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        rreg(OFS_DATA, ~d, "rx data");
      end
      rreg(OFS_STATUS, {7'h00, j[2]}, "cleared");
    end
    wreg(OFS_CONTROL, 8'h50);
    ssin <= 1'b1;
    ss_n <= 1'b0;
    repeat (4) @(posedge clk);
    rreg(OFS_CONTROL, 8'h40, "fault role");
    rreg(OFS_STATUS, 8'h80, "fault flag");
    ss_n <= 1'b1;
    rreg(OFS_DATA, ~d, "buffer kept");
    wreg(OFS_CONTROL, 8'h43);
    ssin <= 1'b0;
    ss_n <= 1'b0;
    sbyte(8'hFF, 3);
    ss_n <= 1'b1;
    repeat (3) @(posedge clk);
    wreg(OFS_DATA, 8'h96);
    ss_n <= 1'b0;
    sbyte(8'h5A, 8);
    `CHK("slave tx", 8'h96, got)
    rreg(OFS_STATUS, 8'h80, "slave done");
    rreg(OFS_DATA, 8'h5A, "slave rx");
    ss_n <= 1'b1;
    $display("tests finished");
    conclude();
  end
endmodule
